// file: pkg/lit_defs.svh
`ifndef LIT_DEFS_SVH
`define LIT_DEFS_SVH

// Register offsets, byte addresses on the internal register port.
`define LIT_CMD_OFS 8'h00
`define LIT_CTRL_OFS 8'h01
`define LIT_DATA_LSB_OFS 8'h04
`define LIT_DATA_MSB_OFS 8'h05
`define LIT_TMR_LSB_OFS 8'h06
`define LIT_TMR_MSB_OFS 8'h07

// Field positions.
`define LIT_CMD_EXT_BIT 5
`define LIT_CTRL_RANGE_HI 3
`define LIT_CTRL_RANGE_LO 2

// Reset values.
`define LIT_CMD_RESET 8'h00
`define LIT_CTRL_RESET 8'h00

// Full-speed oscillator and core clock rates in kHz, and full-speed oscillator period in core cycles.
`define LIT_OSC_FULL_KHZ 684
`define LIT_CORE_KHZ 100000
`define LIT_OSC_FULL_DIV (`LIT_CORE_KHZ / `LIT_OSC_FULL_KHZ)

`endif

// file: pkg/lit_pkg.sv
package lit_pkg;
    // Resolution selection: cycle exponent per code.
    typedef enum logic [1:0] {
        LIT_RES_16 = 2'b00,
        LIT_RES_12 = 2'b01,
        LIT_RES_8 = 2'b10,
        LIT_RES_4 = 2'b11
    } lit_res_t;

    // Register write/read port bundle.
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lit_reg_req_t;

    // Published pair: light result and matching cycle count.
    typedef struct packed {
        logic [15:0] light;
        logic [15:0] cycles;
    } lit_result_t;

    // Conversion phases.
    typedef enum logic [1:0] {
        LIT_IDLE,
        LIT_VIS,
        LIT_IR
    } lit_phase_t;
endpackage : lit_pkg

// file: rtl/lit_cycle_cnt.sv
`timescale 1ns/1ns
// Cycle counter for one integration; saturation is flagged, not wrapped silently.
module lit_cycle_cnt (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic clear,
    input wire logic tick,
    // Count out
    output logic [15:0] count,
    output logic overflow
);
    import lit_pkg::*;

    // Count ticks; clear has priority so a new period starts at zero.
    always_ff @(posedge core_clk) begin
        if (reset || clear) begin
            count <= 16'h0000;
            overflow <= 1'b0;
        end else if (tick) begin
            count <= count + 16'h0001;
            if (count == 16'hFFFF) begin
                overflow <= 1'b1;
            end
        end
    end
endmodule : lit_cycle_cnt

// file: rtl/lit_osc_div.sv
`timescale 1ns/1ns
`include "lit_defs.svh"
// Oscillator tick generator: one-cycle enable at full or half oscillator rate.
module lit_osc_div (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic half_speed,
    // Tick out
    output logic osc_tick
);
    import lit_pkg::*;

    localparam logic [15:0] DIV_FULL = 16'(`LIT_OSC_FULL_DIV);
    logic [15:0] cnt_reg;
    logic tog_reg;
    wire logic wrap = (cnt_reg == DIV_FULL - 16'h0001);

    // Base divider; the half-speed path drops every other base tick so both rates share one counter.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_reg <= 16'h0000;
            tog_reg <= 1'b0;
            osc_tick <= 1'b0;
        end else begin
            cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
            if (wrap) begin
                tog_reg <= ~tog_reg;
            end
            osc_tick <= wrap & (~half_speed | tog_reg);
        end
    end
endmodule : lit_osc_div

// file: rtl/lit_timing.sv
`timescale 1ns/1ns
`include "lit_defs.svh"
// How it works
// - Oscillator runs half speed on the two lowest ranges, full otherwise.
// - Internal mode ends integration after two to the m oscillator cycles.
// - Command bit 5 selects external or internal timing.
// - Command bits 1:0 select the internal cycle exponent.
// - External mode: host sync starts first diode, next sync switches diodes.
// - Third sync ends second diode, publishes result, restarts first diode.
// - External period is both sync intervals; cycles reported in timer register.
// - External cycle count follows host timing, sixteen-bit counter capacity.
// - Oscillator behaves the same in both timing modes.
// - Result is visible-plus-IR measurement minus IR-only measurement.
// - Control bits 3:2 select one of four ranges.
// - Timer counts every oscillator cycle and latches at period end.
module lit_timing (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input lit_pkg::lit_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // External sync command strobe
    input wire logic sync_cmd,
    // Converter counts for each diode
    input wire logic [15:0] visible_ir_diode,
    input wire logic [15:0] ir_only_diode,
    // Converter control
    output logic conv_visible,
    output logic conv_ir,
    // Result status
    output logic result_valid,
    output logic overflow_flag
);
    import lit_pkg::*;

    logic [7:0] cmd_reg;
    logic [7:0] ctrl_reg;
    lit_result_t result_reg;
    lit_phase_t phase_reg;
    logic [15:0] vis_hold_reg;
    logic [15:0] int_cnt_reg;
    logic osc_tick;
    logic [15:0] cyc_count;
    logic cyc_ovf;

    // Cycle target of two to the m; 2^16 wraps to zero and is handled as terminal at FFFF.
    function automatic logic [15:0] res_last(input logic [1:0] res);
        case (res)
            LIT_RES_16: res_last = 16'hFFFF;
            LIT_RES_12: res_last = 16'h0FFF;
            LIT_RES_8: res_last = 16'h00FF;
            default: res_last = 16'h000F;
        endcase
    endfunction : res_last

    // Mode and range decode.
    // timing mode select
    wire logic ext_mode = cmd_reg[`LIT_CMD_EXT_BIT];
    wire logic [1:0] range_sel = ctrl_reg[`LIT_CTRL_RANGE_HI:`LIT_CTRL_RANGE_LO];
    wire logic half_speed = ~range_sel[1];
    wire logic [15:0] int_last = res_last(cmd_reg[1:0]);
    wire logic wr_cmd = reg_req.wr_en && (reg_req.addr == `LIT_CMD_OFS);
    wire logic wr_ctrl = reg_req.wr_en && (reg_req.addr == `LIT_CTRL_OFS);

    // Internal period boundary: half the target per diode so both diodes share the period.
    // internal per-diode interval end
    wire logic [15:0] half_last = {1'b0, int_last[15:1]};
    wire logic int_end = !ext_mode && osc_tick && (int_cnt_reg == half_last);
    wire logic ext_step = ext_mode && sync_cmd;
    wire logic step = int_end || ext_step;
    wire logic finish = step && (phase_reg == LIT_IR);
    // A mode or range change restarts the sequence so no result mixes two settings.
    wire logic restart = wr_cmd || wr_ctrl;

    lit_osc_div u_osc (
        .core_clk(core_clk),
        .reset(reset),
        .half_speed(half_speed),
        .osc_tick(osc_tick)
    );

    lit_cycle_cnt u_cyc (
        .core_clk(core_clk),
        .reset(reset),
        .clear(finish || restart || (phase_reg == LIT_IDLE)),
        .tick(osc_tick),
        .count(cyc_count),
        .overflow(cyc_ovf)
    );

    // Configuration registers.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmd_reg <= `LIT_CMD_RESET;
            ctrl_reg <= `LIT_CTRL_RESET;
        end else begin
            if (wr_cmd) begin
                cmd_reg <= reg_req.wdata;
            end
            if (wr_ctrl) begin
                ctrl_reg <= reg_req.wdata;
            end
        end
    end

    // Per-diode internal counter; held at zero while idle so the first period also spans the full count.
    always_ff @(posedge core_clk) begin
        if (reset || restart || step || ext_mode || (phase_reg == LIT_IDLE)) begin
            int_cnt_reg <= 16'h0000;
        end else if (osc_tick) begin
            int_cnt_reg <= int_cnt_reg + 16'h0001;
        end
    end

    // Conversion sequencer. Internal mode free-runs; external mode waits for the first sync.
    always_ff @(posedge core_clk) begin
        if (reset || restart) begin
            phase_reg <= LIT_IDLE;
        end else begin
            case (phase_reg)
                LIT_IDLE: begin
                    if (!ext_mode || sync_cmd) begin
                        phase_reg <= LIT_VIS;
                    end
                end
                LIT_VIS: begin
                    if (step) begin
                        phase_reg <= LIT_IR;
                    end
                end
                LIT_IR: begin
                    if (step) begin
                        phase_reg <= LIT_VIS;
                    end
                end
                default: phase_reg <= LIT_IDLE;
            endcase
        end
    end

    // Hold first diode count at the diode switch.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            vis_hold_reg <= 16'h0000;
        end else if (step && phase_reg == LIT_VIS) begin
            vis_hold_reg <= visible_ir_diode;
        end
    end

    // Publish the pair in one edge so a read never sees a mixed light and cycle count.
    // atomic pair publish
    always_ff @(posedge core_clk) begin
        if (reset) begin
            result_reg <= '0;
            result_valid <= 1'b0;
            overflow_flag <= 1'b0;
        end else if (finish) begin
            result_reg.light <= vis_hold_reg - ir_only_diode;
            // report elapsed cycles
            // A tick on the closing edge belongs to the period that closes; the counter's clear would drop it.
            result_reg.cycles <= cyc_count + {15'h0000, osc_tick};
            result_valid <= 1'b1;
            overflow_flag <= cyc_ovf || (ext_mode && osc_tick && (cyc_count == 16'hFFFF));
        end
    end

    // Converter controls follow the phase.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            conv_visible <= 1'b0;
            conv_ir <= 1'b0;
        end else begin
            conv_visible <= (phase_reg == LIT_VIS);
            conv_ir <= (phase_reg == LIT_IR);
        end
    end

    // Read mux; unmapped addresses read zero.
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (reg_req.addr)
            `LIT_CMD_OFS: rd_mux = cmd_reg;
            `LIT_CTRL_OFS: rd_mux = ctrl_reg;
            `LIT_DATA_LSB_OFS: rd_mux = result_reg.light[7:0];
            `LIT_DATA_MSB_OFS: rd_mux = result_reg.light[15:8];
            `LIT_TMR_LSB_OFS: rd_mux = result_reg.cycles[7:0];
            `LIT_TMR_MSB_OFS: rd_mux = result_reg.cycles[15:8];
            default: rd_mux = 8'h00;
        endcase
    end

    // Registered read data, one cycle after the read strobe.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd_en) begin
            reg_rdata <= rd_mux;
        end
    end
endmodule : lit_timing

// file: testbench/lit_host_model.sv
`timescale 1ns/1ns
// Host side of the register port and sync strobe; it moves only on falling edges.
module lit_host_model (
    // Clock
    input wire logic core_clk,
    // Register port
    output lit_pkg::lit_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Sync strobe
    output logic sync_cmd
);
    import lit_pkg::*;
    // Quiet bus at time zero.
    initial begin
        reg_req = '0;
        sync_cmd = 1'b0;
    end
    // Idle lines flip so a stale address or datum can never pass for a fresh one.
    task automatic release_bus();
        reg_req.wr_en = 1'b0;
        reg_req.rd_en = 1'b0;
        reg_req.addr = ~reg_req.addr;
        reg_req.wdata = ~reg_req.wdata;
    endtask : release_bus
    // One-cycle write strobe, then one idle cycle so a following strobe never meets its own release.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        reg_req.addr = a;
        reg_req.wdata = d;
        reg_req.wr_en = 1'b1;
        @(negedge core_clk);
        release_bus();
        @(negedge core_clk);
    endtask : write_reg
    // One-cycle read strobe; the registered data stands from the strobe's edge on.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        reg_req.addr = a;
        reg_req.rd_en = 1'b1;
        @(negedge core_clk);
        d = reg_rdata;
        release_bus();
        @(negedge core_clk);
    endtask : read_reg
    // Write followed at once by a read of the same address, with no idle cycle between.
    task automatic write_read(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
        reg_req.addr = a;
        reg_req.wdata = wd;
        reg_req.wr_en = 1'b1;
        @(negedge core_clk);
        reg_req.wr_en = 1'b0;
        reg_req.rd_en = 1'b1;
        @(negedge core_clk);
        rd = reg_rdata;
        release_bus();
        @(negedge core_clk);
    endtask : write_read
    task automatic measure(input int gap);
        repeat (3) begin
            sync_cmd = 1'b1;
            @(negedge core_clk);
            sync_cmd = 1'b0;
            repeat (gap) @(negedge core_clk);
        end
    endtask : measure
endmodule : lit_host_model

// file: testbench/lit_timing_checker.sv
`timescale 1ns/1ns
// Port-level watcher for the timing block.
module lit_timing_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input lit_pkg::lit_reg_req_t reg_req,
    input logic [7:0] reg_rdata,
    // Sync and phases
    input wire logic sync_cmd,
    input logic conv_visible,
    input logic conv_ir,
    input logic result_valid
);
    import lit_pkg::*;
    logic ext_reg;
    // Decodes for the command write and the mapped read addresses.
    wire cmd_wr = reg_req.wr_en && reg_req.addr == 8'h00;
    wire map_hit = reg_req.addr < 8'h02 || (reg_req.addr > 8'h03 && reg_req.addr < 8'h08);
    // Mirror of the mode bit, so the sync checks stay quiet in internal mode.
    always_ff @(posedge core_clk) begin
        ext_reg <= reset ? 1'b0 : cmd_wr ? reg_req.wdata[5] : ext_reg;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    phase_excl_a: assert property (!(conv_visible && conv_ir))
        else $error("both diodes converting");
    valid_sticky_a: assert property (result_valid |=> result_valid)
        else $error("result flag dropped");
    rdata_hold_a: assert property (!reg_req.rd_en |=> $stable(reg_rdata))
        else $error("read data moved");
    unmapped_read_a: assert property (reg_req.rd_en && !map_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    cmd_readback_a: assert property ($past(cmd_wr) && reg_req.rd_en && reg_req.addr == 8'h00
        |=> reg_rdata == $past(reg_req.wdata, 2)) else $error("command readback wrong");
    first_sync_a: assert property (sync_cmd && ext_reg && !conv_visible && !conv_ir && !$past(sync_cmd)
        |=> ##1 conv_visible) else $error("first sync did not start");
    sync_switch_a: assert property (sync_cmd && ext_reg && conv_visible && !$past(sync_cmd)
        |=> ##1 conv_ir) else $error("second sync did not switch");
    restart_vis_a: assert property (sync_cmd && ext_reg && conv_ir && !$past(sync_cmd)
        |=> ##1 conv_visible) else $error("third sync did not restart");
endmodule : lit_timing_checker

// file: testbench/lit_timing_tb_top.sv
`timescale 1ns/1ns
// Bench: host model and converter counts around the timing block.
module lit_timing_tb_top;
    import lit_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] vis = 16'h0010;
    logic [15:0] ir = 16'h0030;
    lit_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic sync_cmd, conv_visible, conv_ir, result_valid, overflow_flag;
    logic [15:0] rd16;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    // 100 MHz clock.
    always #5 core_clk = ~core_clk;
    lit_timing lit_timing_inst (.core_clk(core_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .sync_cmd(sync_cmd), .visible_ir_diode(vis), .ir_only_diode(ir), .conv_visible(conv_visible),
        .conv_ir(conv_ir), .result_valid(result_valid), .overflow_flag(overflow_flag));
    lit_host_model lit_host_model_inst (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .sync_cmd(sync_cmd));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd_pair(input logic [7:0] a);
        logic [7:0] lo;
        logic [7:0] hi;
        lit_host_model_inst.read_reg(a, lo);
        lit_host_model_inst.read_reg(a + 8'h01, hi);
        rd16 = {hi, lo};
    endtask : rd_pair
    task automatic reg_test();
        logic [7:0] d;
        lit_host_model_inst.read_reg(8'h01, d);
        chk("ctrl reset", 16'h0000, {8'h00, d});
        lit_host_model_inst.write_read(8'h00, 8'h23, d);
        chk("command", 16'h0023, {8'h00, d});
        lit_host_model_inst.read_reg(8'h02, d);
        chk("unmapped", 16'h0000, {8'h00, d});
    endtask : reg_test
    // Result wraps because the visible count is below the IR count.
    task automatic ext_run(input logic [7:0] ctrl, input logic [15:0] lo, input logic [15:0] hi);
        lit_host_model_inst.write_reg(8'h01, ctrl);
        lit_host_model_inst.write_reg(8'h00, 8'h20);
        repeat (4) @(negedge core_clk);
        lit_host_model_inst.measure(32'h5B4);
        chk("phase", 16'h0001, {15'h0, conv_visible});
        rd_pair(8'h04);
        chk("light", vis - ir, rd16);
        rd_pair(8'h06);
        chk("cycles", 16'h0001, {15'h0, rd16 >= lo && rd16 <= hi});
        chk("overflow", 16'h0000, {15'h0, overflow_flag});
    endtask : ext_run
    // Equal diode counts read zero; the host rechecks at a high range to tell darkness from saturation.
    // zero recheck
    task automatic dark_check();
        vis = 16'h0020;
        ir = 16'h0020;
        lit_host_model_inst.write_reg(8'h01, 8'h04);
        lit_host_model_inst.write_reg(8'h00, 8'h20);
        repeat (4) @(negedge core_clk);
        lit_host_model_inst.measure(200);
        rd_pair(8'h04);
        chk("dark low range", 16'h0000, rd16);
        if (rd16 === 16'h0000) begin
            lit_host_model_inst.write_reg(8'h01, 8'h0C);
            repeat (4) @(negedge core_clk);
            lit_host_model_inst.measure(200);
            rd_pair(8'h04);
            chk("dark high range", 16'h0000, rd16);
        end
    endtask : dark_check
    // Sixteen ticks at full speed give 2336 core cycles per period.
    task automatic int_run();
        int n;
        vis = 16'h1234;
        ir = 16'h0034;
        lit_host_model_inst.write_reg(8'h01, 8'h0C);
        lit_host_model_inst.write_reg(8'h00, 8'h03);
        @(posedge conv_visible);
        // The first period after a restart starts at an arbitrary oscillator phase, so time the next one.
        @(posedge conv_visible);
        n = 0;
        while (conv_visible === 1'b1) begin
            @(negedge core_clk);
            n++;
        end
        while (conv_visible !== 1'b1) begin
            @(negedge core_clk);
            n++;
        end
        chk("period", 16'h0001, {15'h0, n >= 2334 && n <= 2338});
        rd_pair(8'h06);
        chk("int cycles", 16'h0010, rd16);
        rd_pair(8'h04);
        chk("int light", vis - ir, rd16);
        chk("valid", 16'h0001, {15'h0, result_valid});
    endtask : int_run
    task automatic complete_run();
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // Main sequence after five reset cycles.
    initial begin
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        reg_test();
        ext_run(8'h0C, 16'h0013, 16'h0015);
        ext_run(8'h04, 16'h0009, 16'h000B);
        dark_check();
        int_run();
        complete_run();
    end
    // Hang guard, well above the expected run of some 15000 cycles.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            complete_run();
        end
    end
endmodule : lit_timing_tb_top
bind lit_timing lit_timing_checker lit_timing_checker_inst (.core_clk(core_clk), .reset(reset),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .sync_cmd(sync_cmd), .conv_visible(conv_visible),
    .conv_ir(conv_ir), .result_valid(result_valid));
